// ---- design/srxmap_pkg.sv ----
package srxmap_pkg;

	////////////////////////////////////////////////////////////////////////
	// Serial word and channel geometry
	localparam int WORD_BITS  = 16;
	localparam int BIT_CNT_W  = 4;
	localparam int SLOT_W     = 5;
	localparam int SLOT_CNT_W = 6;
	localparam int CHANS      = 3;
	localparam int FIFO_DEPTH = 16;
	localparam int LEVEL_W    = 5;
	localparam int FIFO_W     = 21;

	// Route register indices; byte address is four times the index
	localparam logic [5:0] IDX_CTRL     = 6'h20;
	localparam logic [5:0] IDX_STATUS   = 6'h21;
	localparam logic [5:0] IDX_LINE_SEL = 6'h27;
	localparam logic [5:0] IDX_CH3      = 6'h2A;
	localparam logic [5:0] IDX_CH4      = 6'h2B;
	localparam logic [5:0] IDX_CH5      = 6'h2C;
	localparam logic [5:0] IDX_CH6      = 6'h2D;

	// Per-channel tables for receive channels 3, 4 and 5
	localparam logic [5:0] CH_IDX  [CHANS] = '{IDX_CH3, IDX_CH4, IDX_CH5};
	localparam logic [7:0] CH_RST  [CHANS] = '{8'h02, 8'h03, 8'h04};
	localparam logic [7:0] CH_MASK [CHANS] = '{8'h3F, 8'h3F, 8'h7F};
	localparam logic [2:0] CH_NUM  [CHANS] = '{3'h3, 3'h4, 3'h5};
	localparam logic [7:0] CH6_RST   = 8'h05;
	localparam logic [7:0] CH6_MASK  = 8'h7F;

	// Field positions
	localparam int ROUTE_LSB  = 5;
	localparam int SLOT_LSB   = 0;
	localparam int SEL_LSB    = 2;
	localparam int FMT_LSB    = 0;
	localparam int ST_OVF     = 0;
	localparam int ST_EMPTY   = 1;
	localparam int ST_LVL_LSB = 4;
	localparam logic [7:0] LINE_SEL_MASK = 8'h1C;
	localparam logic [7:0] LINE_SEL_RST  = 8'h00;
	localparam logic [1:0] FMT_RST       = 2'h0;

	// Serial formats
	localparam logic [1:0] FMT_TDM = 2'h0;
	localparam logic [1:0] FMT_I2S = 2'h1;
	localparam logic [1:0] FMT_LJ  = 2'h2;

	// Route codes
	localparam logic [1:0] ROUTE_OFF  = 2'h0;
	localparam logic [1:0] ROUTE_PLAY = 2'h1;
	localparam logic [1:0] ROUTE_LOOP = 2'h2;
	localparam logic [1:0] ROUTE_RSVD = 2'h3;

endpackage

// ---- design/srxmap_fifo.sv ----
`timescale 1ns/10ps
module srxmap_fifo
	import srxmap_pkg::*;
#(
	parameter int WIDTH = FIFO_W,
	parameter int DEPTH = FIFO_DEPTH
)
(
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       inValid,
	output      logic                       inReady,
	input  wire logic [WIDTH-1:0]           inData,
	output      logic                       outValid,
	input  wire logic                       outReady,
	output      logic [WIDTH-1:0]           outData,
	output      logic [$clog2(DEPTH):0]     level
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0]    wrPtr_q;
	logic [PW-1:0]    rdPtr_q;
	logic [PW:0]      count_q;
	logic             doPush;
	logic             doPop;

	////////////////////////////////////////////////////////////////////////
	// Honest full and empty from the occupancy count
	assign inReady  = (count_q != (PW+1)'(DEPTH));
	assign outValid = (count_q != '0);
	assign outData  = mem_q[rdPtr_q];
	assign level    = count_q;
	assign doPush   = inValid & inReady;
	assign doPop    = outValid & outReady;

	// Storage, written by index
	always_ff @(posedge clk)
	begin
		if (doPush)
			mem_q[wrPtr_q] <= inData;
	end

	// Pointers and count
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			if (doPush)
				wrPtr_q <= wrPtr_q + 1'b1;
			if (doPop)
				rdPtr_q <= rdPtr_q + 1'b1;
			if (doPush && !doPop)
				count_q <= count_q + 1'b1;
			else if (doPop && !doPush)
				count_q <= count_q - 1'b1;
		end
	end
endmodule

// ---- design/srxmap_top.sv ----
// How it works
// - Ch3 bit5: 0 off, 1 playback 3
// - Ch4 bit5: 0 off, 1 playback 4; resets 0
// - Ch5 bits6:5: off, playback 5, loopback, reserved
// - Slot field bits4:0 picks TDM slot 0-31
// - Ch3/ch4 bits7:6 read-only zero
// - Ch5 bit7 read-only zero
// - Ch3 resets to slot 2, disabled
// - Ch4 at 0x2B, resets 0x03
// - Ch5 at 0x2C, resets 0x04
// - Ch6 at 0x2D, resets 0x05
// - Select bit picks data line A or B
`timescale 1ns/10ps
module srxmap_top
	import srxmap_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic [7:0]    address,
	input  wire logic          read,
	input  wire logic          write,
	input  wire logic [31:0]   writedata,
	input  wire logic [3:0]    byteenable,
	output      logic [31:0]   readdata,
	output      logic          waitrequest,
	input  wire logic          serialBitClk,
	input  wire logic          frameSync,
	input  wire logic          serialDataInA,
	input  wire logic          serialDataInB,
	output      logic          outValid,
	input  wire logic          outReady,
	output      logic [15:0]   outData,
	output      logic [2:0]    outChan,
	output      logic [1:0]    outRoute
);

	// Route code of a channel register; reserved code forwards nothing
	function automatic logic [1:0] routeOf(input logic [7:0] cfg,
		input logic wide);
		logic [1:0] r;
		r = wide ? cfg[ROUTE_LSB+1 -: 2] : {1'b0, cfg[ROUTE_LSB]};
		return (r == ROUTE_RSVD) ? ROUTE_OFF : r;
	endfunction

	logic [7:0]            chanCfg_q [CHANS];
	logic [7:0]            ch6Cfg_q;
	logic [7:0]            lineSel_q;
	logic [1:0]            fmt_q;
	logic                  overflow_q;
	logic                  waitReq_q;
	logic [31:0]           readData_q;
	logic [5:0]            regIdx;
	logic                  accept;
	logic                  wrLow;
	logic [31:0]           readMux;
	logic [3:0]            pinMeta_q;
	logic [3:0]            pinSync_q;
	logic                  bitClkPrev_q;
	logic                  tick;
	logic                  fsPrev_q;
	logic                  fsRiseD_q;
	logic                  fsFallD_q;
	logic                  fsRise;
	logic                  fsFall;
	logic                  startLeft;
	logic                  startRight;
	logic                  active_q;
	logic                  halfRight_q;
	logic [BIT_CNT_W-1:0]  bitCnt_q;
	logic [SLOT_CNT_W-1:0] slotCnt_q;
	logic [WORD_BITS-1:0]  shA_q;
	logic [WORD_BITS-1:0]  shB_q;
	logic [WORD_BITS-1:0]  wordA;
	logic [WORD_BITS-1:0]  wordB;
	logic                  wordDone;
	logic [SLOT_W-1:0]     curSlot;
	logic                  slotValid;
	logic [CHANS-1:0]      hit;
	logic [CHANS-1:0]      pend_q;
	logic [CHANS-1:0]      pushOne;
	logic [WORD_BITS-1:0]  capWord_q  [CHANS];
	logic [1:0]            capRoute_q [CHANS];
	logic                  pushValid;
	logic [FIFO_W-1:0]     pushData;
	logic                  fifoInReady;
	logic                  fifoOutValid;
	logic                  fifoOutReady;
	logic [FIFO_W-1:0]     fifoOutData;
	logic [LEVEL_W-1:0]    fifoLevel;

	////////////////////////////////////////////////////////////////////////
	// Avalon slave: one wait cycle, then a single acknowledge cycle
	assign regIdx = address[7:2];
	assign accept = (read | write) & ~waitReq_q;
	assign wrLow  = accept & write & byteenable[0];

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			waitReq_q <= 1'b1;
		else
			waitReq_q <= ~(waitReq_q & (read | write));
	end

	// Read mux; unmapped and reserved bits read as zero
	always_comb
	begin
		readMux = '0;
		unique case (regIdx)
			IDX_CTRL:     readMux[1:0] = fmt_q;
			IDX_STATUS:
			begin
				readMux[ST_OVF]   = overflow_q;
				readMux[ST_EMPTY] = ~fifoOutValid;
				readMux[ST_LVL_LSB +: LEVEL_W] = fifoLevel;
			end
			IDX_LINE_SEL: readMux[7:0] = lineSel_q;
			IDX_CH3:      readMux[7:0] = chanCfg_q[0];
			IDX_CH4:      readMux[7:0] = chanCfg_q[1];
			IDX_CH5:      readMux[7:0] = chanCfg_q[2];
			IDX_CH6:      readMux[7:0] = ch6Cfg_q;
			default:      readMux = '0;
		endcase
	end

	// Read data captured in the wait cycle, stands through the acknowledge
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			readData_q <= '0;
		else if (waitReq_q && read)
			readData_q <= readMux;
	end

	////////////////////////////////////////////////////////////////////////
	// Channel route registers 3 to 5
	generate
		for (genvar c = 0; c < CHANS; c++)
		begin : g_cfg
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					chanCfg_q[c] <= CH_RST[c];
				else if (wrLow && regIdx == CH_IDX[c])
					chanCfg_q[c] <= writedata[7:0] & CH_MASK[c];
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ch6Cfg_q <= CH6_RST;
		else if (wrLow && regIdx == IDX_CH6)
			ch6Cfg_q <= writedata[7:0] & CH6_MASK;
	end

	// Line select and format control
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lineSel_q <= LINE_SEL_RST;
			fmt_q     <= FMT_RST;
		end
		else
		begin
			if (wrLow && regIdx == IDX_LINE_SEL)
				lineSel_q <= writedata[7:0] & LINE_SEL_MASK;
			if (wrLow && regIdx == IDX_CTRL)
				fmt_q <= writedata[FMT_LSB +: 2];
		end
	end

	// Overflow is sticky; a new loss wins over a write-one clear
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			overflow_q <= 1'b0;
		else if (|(hit & pend_q))
			overflow_q <= 1'b1;
		else if (wrLow && regIdx == IDX_STATUS && writedata[ST_OVF])
			overflow_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Pins cross into clk: second stage is the only reader of the first
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pinMeta_q    <= '0;
			pinSync_q    <= '0;
			bitClkPrev_q <= 1'b0;
		end
		else
		begin
			pinMeta_q    <= {serialDataInB, serialDataInA, frameSync,
				serialBitClk};
			pinSync_q    <= pinMeta_q;
			bitClkPrev_q <= pinSync_q[0];
		end
	end

	// Bit clock rising edge as a one-cycle enable
	assign tick   = pinSync_q[0] & ~bitClkPrev_q;
	assign fsRise = pinSync_q[1] & ~fsPrev_q;
	assign fsFall = ~pinSync_q[1] & fsPrev_q;

	// Half starts; I2S lags the frame sync edge by one bit
	always_comb
	begin
		startLeft  = 1'b0;
		startRight = 1'b0;
		unique case (fmt_q)
			FMT_I2S:
			begin
				startLeft  = fsFallD_q;
				startRight = fsRiseD_q;
			end
			FMT_LJ:
			begin
				startLeft  = fsRise;
				startRight = fsFall;
			end
			default: startLeft = fsRise;
		endcase
	end

	// Frame position: bit and slot counters on each bit clock rising edge
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fsPrev_q    <= 1'b0;
			fsRiseD_q   <= 1'b0;
			fsFallD_q   <= 1'b0;
			active_q    <= 1'b0;
			halfRight_q <= 1'b0;
			bitCnt_q    <= '0;
			slotCnt_q   <= '0;
		end
		else if (tick)
		begin
			fsPrev_q  <= pinSync_q[1];
			fsRiseD_q <= fsRise;
			fsFallD_q <= fsFall;
			if (startLeft || startRight)
			begin
				active_q    <= 1'b1;
				halfRight_q <= startRight;
				bitCnt_q    <= BIT_CNT_W'(1);
				slotCnt_q   <= '0;
			end
			else
			begin
				bitCnt_q <= bitCnt_q + 1'b1;
				// Saturate so a long frame never aliases to slot 0
				if (wordDone && !slotCnt_q[SLOT_CNT_W-1])
					slotCnt_q <= slotCnt_q + 1'b1;
			end
		end
	end

	// Both data lines shift so any channel may pick either
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shA_q <= '0;
			shB_q <= '0;
		end
		else if (tick)
		begin
			shA_q <= wordA;
			shB_q <= wordB;
		end
	end

	assign wordA    = {shA_q[WORD_BITS-2:0], pinSync_q[2]};
	assign wordB    = {shB_q[WORD_BITS-2:0], pinSync_q[3]};
	assign wordDone = tick & active_q & ~startLeft & ~startRight
		& (bitCnt_q == BIT_CNT_W'(WORD_BITS - 1));

	// effective slot number of the word just finished
	always_comb
	begin
		if (fmt_q == FMT_I2S || fmt_q == FMT_LJ)
		begin
			curSlot   = {halfRight_q, slotCnt_q[SLOT_W-2:0]};
			slotValid = (slotCnt_q[SLOT_CNT_W-1 -: 2] == 2'b00);
		end
		else
		begin
			// Format code 3 counts slots as TDM, as its frame start does
			curSlot   = slotCnt_q[SLOT_W-1:0];
			slotValid = ~slotCnt_q[SLOT_CNT_W-1];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-channel capture; the push stalls on a full FIFO
	generate
		for (genvar c = 0; c < CHANS; c++)
		begin : g_cap
			assign hit[c] = wordDone & slotValid
				& (routeOf(chanCfg_q[c], c == CHANS - 1) != ROUTE_OFF)
				& (chanCfg_q[c][SLOT_LSB +: SLOT_W] == curSlot);

			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					capWord_q[c]  <= '0;
					capRoute_q[c] <= ROUTE_OFF;
					pend_q[c]     <= 1'b0;
				end
				else if (hit[c])
				begin
					capWord_q[c]  <= lineSel_q[SEL_LSB + c] ? wordB : wordA;
					capRoute_q[c] <= routeOf(chanCfg_q[c], c == CHANS - 1);
					pend_q[c]     <= 1'b1;
				end
				else if (pushOne[c])
					pend_q[c] <= 1'b0;
			end
		end
	endgenerate

	// Lowest pending channel goes first, one word per cycle
	always_comb
	begin
		pushOne  = '0;
		pushData = '0;
		for (int c = CHANS - 1; c >= 0; c--)
		begin
			if (pend_q[c])
			begin
				pushOne  = '0;
				pushOne[c] = fifoInReady;
				pushData = {capRoute_q[c], CH_NUM[c], capWord_q[c]};
			end
		end
	end

	assign pushValid = |pend_q;

	srxmap_fifo #(
		.WIDTH (FIFO_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk      (clk),
		.rst_n    (rst_n),
		.inValid  (pushValid),
		.inReady  (fifoInReady),
		.inData   (pushData),
		.outValid (fifoOutValid),
		.outReady (fifoOutReady),
		.outData  (fifoOutData),
		.level    (fifoLevel)
	);

	////////////////////////////////////////////////////////////////////////
	// Registered output stage keeps every output on a flip-flop
	assign fifoOutReady = ~outValid | outReady;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			outValid <= 1'b0;
			outData  <= '0;
			outChan  <= '0;
			outRoute <= ROUTE_OFF;
		end
		else if (fifoOutReady)
		begin
			outValid <= fifoOutValid;
			if (fifoOutValid)
			begin
				outData  <= fifoOutData[WORD_BITS-1:0];
				outChan  <= fifoOutData[WORD_BITS +: 3];
				outRoute <= fifoOutData[FIFO_W-1 -: 2];
			end
		end
	end

	assign readdata    = readData_q;
	assign waitrequest = waitReq_q;

endmodule

// ---- test/srxmap_sva.sv ----
`timescale 1ns/10ps
module srxmap_sva
	import srxmap_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic [7:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic        outValid,
	input wire logic        outReady,
	input wire logic [15:0] outData,
	input wire logic [2:0]  outChan,
	input wire logic [1:0]  outRoute
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// Request steps: held strobe, then a one-cycle acknowledge
	sequence busReq;
		(read || write) && waitrequest;
	endsequence
	sequence busAck;
		!waitrequest ##1 waitrequest;
	endsequence

	logic [5:0] regIdx;
	logic       rdAck;
	// Decode once so the field checks stay short
	assign regIdx = address[7:2];
	assign rdAck = read && !waitrequest;

	////////////////////////////////////////////////////////////////////
	bus_ack_a: assert property (busReq |=> busAck)
		else $error("bus request not answered after one wait cycle");
	ack_cause_a: assert property ($fell(waitrequest) |->
		$past(read || write))
		else $error("acknowledge without a request");
	upper_zero_a: assert property (rdAck |-> readdata[31:9] == 23'h0 &&
		(regIdx == IDX_STATUS || !readdata[8]))
		else $error("upper read bits not zero");
	rsvd_pair_a: assert property (rdAck &&
		(regIdx == IDX_CH3 || regIdx == IDX_CH4) |-> readdata[7:6] == 2'h0)
		else $error("reserved pair of bits read nonzero");
	rsvd_top_a: assert property (rdAck &&
		(regIdx == IDX_CH5 || regIdx == IDX_CH6) |-> readdata[7] == 1'h0)
		else $error("reserved top bit read nonzero");
	out_hold_a: assert property (outValid && !outReady |=> outValid &&
		$stable(outData) && $stable(outChan) && $stable(outRoute))
		else $error("output word changed while stalled");
	route_code_a: assert property (outValid |->
		outRoute == ROUTE_PLAY || (outRoute == ROUTE_LOOP && outChan == 3'h5))
		else $error("illegal destination on output word");
	chan_range_a: assert property (outValid |->
		outChan inside {3'h3, 3'h4, 3'h5})
		else $error("output channel out of range");
endmodule

bind srxmap_top srxmap_sva srxmap_sva_inst (.clk(clk), .rst_n(rst_n),
	.address(address), .read(read), .write(write), .readdata(readdata),
	.waitrequest(waitrequest), .outValid(outValid), .outReady(outReady),
	.outData(outData), .outChan(outChan), .outRoute(outRoute));

// ---- test/srxmap_link_model.sv ----
`timescale 1ns/10ps
module srxmap_link_model
(
	input  wire logic clk,
	output logic      serialBitClk,
	output logic      frameSync,
	output logic      serialDataInA,
	output logic      serialDataInB
);
	// Bit clock stands low outside frames
	initial
	begin
		serialBitClk = 1'h0;
		frameSync = 1'h0;
		serialDataInA = 1'h0;
		serialDataInB = 1'h0;
	end

	// One word per line, MSB first; frame sync given bit by bit
	// 8 clk per bit, data moves while the bit clock is low
	task automatic word(input logic [15:0] fs,
		input logic [15:0] a, input logic [15:0] b);
		for (int i = 15; i >= 0; i--)
		begin
			frameSync <= fs[i];
			serialDataInA <= a[i];
			serialDataInB <= b[i];
			repeat (4) @(posedge clk);
			serialBitClk <= 1'h1;
			repeat (4) @(posedge clk);
			serialBitClk <= 1'h0;
		end
	endtask

	// Released lines flip so a stale bit can never pass as data
	task automatic idle();
		frameSync <= 1'h0;
		serialDataInA <= ~serialDataInA;
		serialDataInB <= ~serialDataInB;
		repeat (8) @(posedge clk);
	endtask
endmodule

// ---- test/srxmap_top_bench.sv ----
`timescale 1ns/10ps
module srxmap_top_bench import srxmap_pkg::*;;
	logic        clk, rst_n, read, write, waitrequest, outValid, outReady;
	logic        serialBitClk, frameSync, serialDataInA, serialDataInB;
	logic [7:0]  address;
	logic [31:0] writedata, readdata, rd;
	logic [3:0]  byteenable;
	logic [15:0] outData;
	logic [2:0]  outChan;
	logic [1:0]  outRoute;
	int          nErrors, nTests, cycles;
	logic [5:0]  idxTab [4] = '{6'h2A, 6'h2B, 6'h2C, 6'h2D};
	logic [7:0]  rstTab [4] = '{8'h02, 8'h03, 8'h04, 8'h05};
	logic [7:0]  mskTab [4] = '{8'h3F, 8'h3F, 8'h7F, 8'h7F};

	srxmap_top srxmap_top_inst (.clk(clk), .rst_n(rst_n),
		.address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest),
		.serialBitClk(serialBitClk), .frameSync(frameSync),
		.serialDataInA(serialDataInA), .serialDataInB(serialDataInB),
		.outValid(outValid), .outReady(outReady), .outData(outData),
		.outChan(outChan), .outRoute(outRoute));
	srxmap_link_model srxmap_link_model_inst (.clk(clk),
		.serialBitClk(serialBitClk), .frameSync(frameSync),
		.serialDataInA(serialDataInA), .serialDataInB(serialDataInB));

	initial
	begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", nTests, nErrors);
		if (nErrors == 0 && nTests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		nTests++;
		if (seen !== exp)
		begin
			nErrors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Request held until waitrequest is sampled low, then released
	// Only the watchdog ends a wait that never gets its answer
	task automatic bus(input logic [5:0] idx, input logic wr,
		input logic [7:0] wd, input logic [3:0] be);
		address <= {idx, 2'h0};
		read <= !wr;
		write <= wr;
		writedata <= {24'h0, wd};
		byteenable <= be;
		do
			@(posedge clk);
		while (waitrequest !== 1'h0);
		rd = readdata;
		read <= 1'h0;
		write <= 1'h0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		bus(idx, 1'h1, d, 4'hF);
	endtask

	task automatic rdchk(input string what, input logic [5:0] idx,
		input logic [7:0] exp);
		bus(idx, 1'h0, 8'h00, 4'hF);
		check(what, rd, {24'h0, exp});
	endtask

	// Consumer stalls until asked, then takes exactly one word
	task automatic pop(input logic [15:0] d, input logic [2:0] c,
		input logic [1:0] r);
		while (outValid !== 1'h1)
			@(posedge clk);
		check("valid", 32'(outValid), 32'h1);
		check("data", 32'(outData), 32'(d));
		check("chan", 32'(outChan), 32'(c));
		check("route", 32'(outRoute), 32'(r));
		outReady <= 1'h1;
		@(posedge clk);
		outReady <= 1'h0;
		@(posedge clk);
	endtask

	// Watchdog well above the roughly 6200 cycles the run needs
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			nErrors++;
			summarize();
		end
	end

	////////////////////////////////////////////////////////////////////
	initial
	begin
		rst_n = 1'h0;
		address = 8'h00;
		read = 1'h0;
		write = 1'h0;
		writedata = 32'h0;
		byteenable = 4'h0;
		outReady = 1'h0;
		nErrors = 0;
		nTests = 0;
		cycles = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		// Reset values, then every writable bit set
		for (int i = 0; i < 4; i++)
		begin
			rdchk("reset", idxTab[i], rstTab[i]);
			// reserved bits written as zero only
			wr(idxTab[i], mskTab[i]);
			rdchk("reserved", idxTab[i], mskTab[i]);
		end
		wr(6'h30, 8'h5A);
		rdchk("unmapped", 6'h30, 8'h00);
		bus(IDX_CH4, 1'h1, 8'h00, 4'h0);
		rdchk("byteenable", IDX_CH4, 8'h3F);
		// TDM: ch3 slot 0 and ch5 slot 1 on line B, ch4 slot 31
		wr(IDX_CTRL, 8'h00);
		wr(IDX_LINE_SEL, 8'h14);
		wr(IDX_CH3, 8'h20);
		wr(IDX_CH5, 8'h41);
		for (int k = 0; k < 32; k++)
			srxmap_link_model_inst.word({k == 0, 15'h0},
				{11'h500, k[4:0]}, {11'h580, k[4:0]});
		srxmap_link_model_inst.idle();
		pop(16'hB000, 3'h3, 2'h1);
		pop(16'hB001, 3'h5, 2'h2);
		pop(16'hA01F, 3'h4, 2'h1);
		// Disabled ch3 and reserved ch5 code must forward nothing
		wr(IDX_LINE_SEL, 8'h00);
		wr(IDX_CH3, 8'h00);
		wr(IDX_CH4, 8'h25);
		wr(IDX_CH5, 8'h65);
		for (int k = 0; k < 6; k++)
			srxmap_link_model_inst.word({k == 0, 15'h0},
				{11'h500, k[4:0]}, {11'h580, k[4:0]});
		srxmap_link_model_inst.idle();
		pop(16'hA005, 3'h4, 2'h1);
		repeat (40) @(posedge clk);
		check("extra", 32'(outValid), 32'h0);
		rdchk("status", IDX_STATUS, 8'h02);
		// Left-justified: right half holds slots 16 and 17
		wr(IDX_CTRL, 8'h02);
		wr(IDX_CH3, 8'h30);
		wr(IDX_CH4, 8'h21);
		wr(IDX_CH5, 8'h31);
		srxmap_link_model_inst.word(16'hFFFF, 16'h1100, 16'h0F00);
		srxmap_link_model_inst.word(16'hFFFF, 16'h1101, 16'h0F01);
		srxmap_link_model_inst.word(16'h0000, 16'h2200, 16'h0F02);
		srxmap_link_model_inst.word(16'h0000, 16'h2201, 16'h0F03);
		srxmap_link_model_inst.idle();
		pop(16'h1101, 3'h4, 2'h1);
		pop(16'h2200, 3'h3, 2'h1);
		pop(16'h2201, 3'h5, 2'h1);
		// I2S: each half starts one bit after its frame sync edge
		wr(IDX_CTRL, 8'h01);
		wr(IDX_CH3, 8'h21);
		wr(IDX_CH4, 8'h30);
		wr(IDX_CH5, 8'h51);
		srxmap_link_model_inst.word(16'hFFFE, 16'h5555, 16'h0F04);
		srxmap_link_model_inst.word(16'h0000, 16'h3300, 16'h0F05);
		srxmap_link_model_inst.word(16'h0001, 16'h3301, 16'h0F06);
		srxmap_link_model_inst.word(16'hFFFF, 16'h4400, 16'h0F07);
		srxmap_link_model_inst.word(16'hFFFF, 16'h4401, 16'h0F08);
		srxmap_link_model_inst.idle();
		pop(16'h3301, 3'h3, 2'h1);
		pop(16'h4400, 3'h4, 2'h1);
		pop(16'h4401, 3'h5, 2'h2);
		summarize();
	end
endmodule
